/* shared/pse_gsc_pkg.sv */
// package: register map, field layout and reset values of the global status/config bank
package pse_gsc_pkg;
  // register offsets on the serial register port
  localparam logic [7:0] ADDR_EVT_ALIAS = 8'h03;
  localparam logic [7:0] ADDR_STATUS = 8'h05;
  localparam logic [7:0] ADDR_TEMP = 8'h06;
  localparam logic [7:0] ADDR_VSUP_LO = 8'h07;
  localparam logic [7:0] ADDR_VSUP_HI = 8'h08;
  localparam logic [7:0] ADDR_CONFIG = 8'h0a;
  // thermal event field in the clear-on-read alias
  localparam int EVT_TSD_BIT = 3;
  // global status fields
  localparam int STAT_ADDR_LSB = 2;
  localparam int STAT_ADDR_MSB = 6;
  localparam int STAT_AUTO_BIT = 0;
  localparam logic [7:0] STATUS_RESET = 8'h00;
  // global config fields
  localparam int CFG_INT_GATE_BIT = 7;
  localparam int CFG_DET_CHG_BIT = 6;
  localparam int CFG_TSD_DIS_BIT = 5;
  localparam int CFG_WD_DIS_LSB = 1;
  localparam int CFG_WD_DIS_MSB = 4;
  localparam int CFG_WD_STAT_BIT = 0;
  localparam logic [7:0] CONFIG_RESET = 8'h96;
  // slave address: fixed top bit above the four strap pins
  localparam logic ADDR_PREFIX = 1'b0;
  localparam int STRAP_W = 4;
  // wait after reset release before the straps are sampled (covers the synchronisers)
  localparam logic [2:0] CAPTURE_CYCLES = 3'h4;
  // detection ports and result width
  localparam int DET_PORTS = 8;
  localparam int DET_RES_W = 3;
endpackage : pse_gsc_pkg

/* hdl/pse_gsc_sync.sv */
// three-flop pin synchroniser with agreement filter
`timescale 1ns/1ps
`default_nettype none
module pse_gsc_sync #(
  parameter int W = 1
) (
  input wire logic i_clk,
  input wire logic i_rst_b,
  input wire logic [W-1:0] i_pin,
  output var logic [W-1:0] o_level
);
  logic [W-1:0] s1_q, s2_q, s3_q, lvl_q, lvl_d;

  // a change is accepted only once stages two and three agree
  always_comb begin
    lvl_d = lvl_q;
    for (int i = 0; i < W; i++) begin
      if (s2_q[i] == s3_q[i]) begin
        lvl_d[i] = s3_q[i];
      end
    end
  end

  // first stage feeds only the second
  always_ff @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      s1_q <= '0;
      s2_q <= '0;
      s3_q <= '0;
      lvl_q <= '0;
    end else begin
      s1_q <= i_pin;
      s2_q <= s1_q;
      s3_q <= s2_q;
      lvl_q <= lvl_d;
    end
  end

  assign o_level = lvl_q;
endmodule : pse_gsc_sync
`default_nettype wire

/* hdl/pse_gsc_top.sv */
// global status and configuration register bank of the eight-port power controller
// Functional notes
// - set thermal shutdown flag when all powered ports shut down for over-temperature
// - thermal flag stays latched until host reads the clear-on-read alias
// - flag zero means die below active threshold, chosen by shutdown-disable bit
// - event bits 2:0 and status bits 7 and 1 read as zero
// - status bits 6:2 give slave address from straps sampled after reset
// - status bit 0 holds autonomous-mode pin, captured once after reset
// - temperature register holds code N, degrees equal -20 plus N times 0.652
// - full code range spans about -20 to 146 degrees
// - supply reading is 16 bits, low byte then high byte address
// - reading low byte freezes high byte until high byte is read
// - config layout: int gate, detect-change-only, tsd disable, watchdog code, wd flag
// - config resets to 1001 0110, status resets to zero
// - detect-change-only gates detection-done events to changed results
`timescale 1ns/1ps
`default_nettype none
module pse_gsc_top (
  input wire logic i_clk,
  input wire logic i_rst_b,
  // register port from the serial interface front end
  input wire logic [7:0] i_reg_addr,
  input wire logic i_reg_rd,
  input wire logic i_reg_wr,
  input wire logic [7:0] i_reg_wdata,
  output logic [7:0] o_reg_rdata,
  output logic o_reg_rvalid,
  // pins sampled once after reset
  input wire logic [pse_gsc_pkg::STRAP_W-1:0] i_addr_strap,
  input wire logic i_auto_pin,
  // on-die sources, same clock
  input wire logic i_tsd_shutdown,
  input wire logic [7:0] i_die_temp,
  input wire logic [15:0] i_supply_meas,
  input wire logic [pse_gsc_pkg::DET_PORTS-1:0] i_det_done,
  input wire logic [pse_gsc_pkg::DET_PORTS*pse_gsc_pkg::DET_RES_W-1:0] i_det_result,
  // configuration and event outputs
  output logic [7:0] o_config,
  output logic o_tsd_disable,
  output logic o_thermal_event,
  output logic [4:0] o_slave_addr,
  output logic o_auto_mode,
  output logic [pse_gsc_pkg::DET_PORTS-1:0] o_det_event
);
  import pse_gsc_pkg::*;

  ////////////////////////////////////////////////////////////////////////////
  // reset release and pin synchronisers

  logic rst_s1_q, rst_b_q;
  logic [STRAP_W-1:0] strap_s;
  logic auto_s;

  // release is synchronous so nothing sees a half-released reset
  always_ff @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      rst_s1_q <= 1'b0;
      rst_b_q <= 1'b0;
    end else begin
      rst_s1_q <= 1'b1;
      rst_b_q <= rst_s1_q;
    end
  end

  pse_gsc_sync #(.W(STRAP_W + 1)) u_pin_sync (
    .i_clk(i_clk),
    .i_rst_b(rst_b_q),
    .i_pin({i_auto_pin, i_addr_strap}),
    .o_level({auto_s, strap_s})
  );

  // decode of the register port, used by the thermal flag and config groups and the assertions
  function automatic logic hit(input logic [7:0] a, input logic [7:0] ref_addr);
    hit = (a == ref_addr);
  endfunction : hit

  ////////////////////////////////////////////////////////////////////////////
  // one-shot capture of straps and mode pin

  logic [2:0] cap_cnt_q, cap_cnt_d;
  logic captured_q, captured_d;
  logic [7:0] status_q, status_d;
  logic cap_now;

  assign cap_now = !captured_q && (cap_cnt_q == CAPTURE_CYCLES);

  // straps are re-sampled only after a reset, a pin change later is invisible
  always_comb begin
    cap_cnt_d = cap_cnt_q;
    captured_d = captured_q;
    status_d = status_q;
    if (!captured_q) begin
      cap_cnt_d = cap_cnt_q + 3'h1;
    end
    if (cap_now) begin
      captured_d = 1'b1;
      status_d = STATUS_RESET;
      status_d[STAT_ADDR_MSB:STAT_ADDR_LSB] = {ADDR_PREFIX, strap_s};
      status_d[STAT_AUTO_BIT] = auto_s;
    end
  end

  always_ff @(posedge i_clk or negedge rst_b_q) begin
    if (!rst_b_q) begin
      cap_cnt_q <= 3'h0;
      captured_q <= 1'b0;
      status_q <= STATUS_RESET;
    end else begin
      cap_cnt_q <= cap_cnt_d;
      captured_q <= captured_d;
      status_q <= status_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // thermal shutdown event flag

  logic tsd_q, tsd_d;
  logic alias_rd;

  assign alias_rd = i_reg_rd && hit(i_reg_addr, ADDR_EVT_ALIAS);

  // a shutdown in the same cycle as the clearing read wins
  always_comb begin
    tsd_d = tsd_q;
    if (alias_rd) begin
      tsd_d = 1'b0;
    end
    if (i_tsd_shutdown) begin
      tsd_d = 1'b1;
    end
  end

  always_ff @(posedge i_clk or negedge rst_b_q) begin
    if (!rst_b_q) begin
      tsd_q <= 1'b0;
    end else begin
      tsd_q <= tsd_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // configuration register and supply high-byte latch

  logic [7:0] cfg_q, cfg_d;
  logic [7:0] vhi_hold_q, vhi_hold_d;
  logic vhi_held_q, vhi_held_d;

  // only the config offset takes writes; everything else is read-only
  always_comb begin
    cfg_d = cfg_q;
    vhi_hold_d = vhi_hold_q;
    vhi_held_d = vhi_held_q;
    if (i_reg_wr && hit(i_reg_addr, ADDR_CONFIG)) begin
      cfg_d = i_reg_wdata;
    end
    if (i_reg_rd && hit(i_reg_addr, ADDR_VSUP_LO)) begin
      vhi_hold_d = i_supply_meas[15:8];
      vhi_held_d = 1'b1;
    end else if (i_reg_rd && hit(i_reg_addr, ADDR_VSUP_HI)) begin
      vhi_held_d = 1'b0;
    end
  end

  always_ff @(posedge i_clk or negedge rst_b_q) begin
    if (!rst_b_q) begin
      cfg_q <= CONFIG_RESET;
      vhi_hold_q <= 8'h00;
      vhi_held_q <= 1'b0;
    end else begin
      cfg_q <= cfg_d;
      vhi_hold_q <= vhi_hold_d;
      vhi_held_q <= vhi_held_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // read data path

  logic [7:0] rdata_q, rdata_d;
  logic rvalid_q, rvalid_d;

  // one-cycle latency; unmapped offsets read as zero
  always_comb begin
    rdata_d = rdata_q;
    rvalid_d = i_reg_rd;
    if (i_reg_rd) begin
      case (i_reg_addr)
        ADDR_EVT_ALIAS: rdata_d = 8'(tsd_q) << EVT_TSD_BIT;
        ADDR_STATUS: rdata_d = status_q;
        ADDR_TEMP: rdata_d = i_die_temp;
        ADDR_VSUP_LO: rdata_d = i_supply_meas[7:0];
        ADDR_VSUP_HI: rdata_d = vhi_held_q ? vhi_hold_q : i_supply_meas[15:8];
        ADDR_CONFIG: rdata_d = cfg_q;
        default: rdata_d = 8'h00;
      endcase
    end
  end

  always_ff @(posedge i_clk or negedge rst_b_q) begin
    if (!rst_b_q) begin
      rdata_q <= 8'h00;
      rvalid_q <= 1'b0;
    end else begin
      rdata_q <= rdata_d;
      rvalid_q <= rvalid_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // detection-done event filter

  logic [DET_RES_W-1:0] det_prev_q [DET_PORTS];
  logic [DET_RES_W-1:0] det_prev_d [DET_PORTS];
  logic [DET_PORTS-1:0] det_evt_q, det_evt_d;

  // first detection after reset compares against zero
  always_comb begin
    for (int p = 0; p < DET_PORTS; p++) begin
      det_prev_d[p] = det_prev_q[p];
      det_evt_d[p] = 1'b0;
      if (i_det_done[p]) begin
        det_prev_d[p] = i_det_result[p*DET_RES_W +: DET_RES_W];
        det_evt_d[p] = !cfg_q[CFG_DET_CHG_BIT] ||
                       (i_det_result[p*DET_RES_W +: DET_RES_W] != det_prev_q[p]);
      end
    end
  end

  always_ff @(posedge i_clk or negedge rst_b_q) begin
    if (!rst_b_q) begin
      for (int p = 0; p < DET_PORTS; p++) begin
        det_prev_q[p] <= '0;
      end
      det_evt_q <= '0;
    end else begin
      det_prev_q <= det_prev_d;
      det_evt_q <= det_evt_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // outputs, all straight from flops

  assign o_reg_rdata = rdata_q;
  assign o_reg_rvalid = rvalid_q;
  assign o_config = cfg_q;
  assign o_tsd_disable = cfg_q[CFG_TSD_DIS_BIT];
  assign o_thermal_event = tsd_q;
  assign o_slave_addr = status_q[STAT_ADDR_MSB:STAT_ADDR_LSB];
  assign o_auto_mode = status_q[STAT_AUTO_BIT];
  assign o_det_event = det_evt_q;

  ////////////////////////////////////////////////////////////////////////////
  // assertions

  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!rst_b_q);

  a_tsd_set: assert property (i_tsd_shutdown |=> tsd_q && o_thermal_event)
    else $error("thermal flag not set after shutdown");

  a_tsd_clear: assert property (alias_rd && !i_tsd_shutdown |=> !tsd_q)
    else $error("thermal flag not cleared by alias read");

  a_tsd_latch: assert property (tsd_q && !alias_rd |=> tsd_q)
    else $error("thermal flag dropped without alias read");

  a_alias_rsv: assert property (alias_rd |=> o_reg_rvalid && o_reg_rdata[2:0] == 3'h0
                                 && o_reg_rdata[EVT_TSD_BIT] == $past(tsd_q))
    else $error("clear-on-read data wrong");

  a_status_rsv: assert property (i_reg_rd && hit(i_reg_addr, ADDR_STATUS)
                                 |=> !o_reg_rdata[7] && !o_reg_rdata[1])
    else $error("status reserved bit set");

  a_strap_capture: assert property (cap_now |=>
                                    o_slave_addr == {ADDR_PREFIX, $past(strap_s)}
                                    && o_auto_mode == $past(auto_s))
    else $error("straps not captured");

  a_status_frozen: assert property (captured_q |=> $stable(status_q))
    else $error("status changed after capture");

  a_temp_read: assert property (i_reg_rd && hit(i_reg_addr, ADDR_TEMP)
                                |=> o_reg_rdata == $past(i_die_temp))
    else $error("temperature read wrong");

  a_volt_pair: assert property (i_reg_rd && hit(i_reg_addr, ADDR_VSUP_LO)
                                ##1 (i_reg_rd && hit(i_reg_addr, ADDR_VSUP_HI))
                                |=> o_reg_rdata == $past(i_supply_meas[15:8], 2))
    else $error("high byte not frozen by low read");

  // the host usually leaves an idle cycle between reads; the byte must still be frozen
  a_volt_gap: assert property (i_reg_rd && hit(i_reg_addr, ADDR_VSUP_LO) ##1 !i_reg_rd
                               ##1 (i_reg_rd && hit(i_reg_addr, ADDR_VSUP_HI))
                               |=> o_reg_rdata == $past(i_supply_meas[15:8], 3))
    else $error("high byte not frozen across idle cycle");

  a_cfg_reset: assert property ($rose(rst_b_q) |-> cfg_q == CONFIG_RESET)
    else $error("config reset value wrong");

  a_ro_ignore: assert property (i_reg_wr && !hit(i_reg_addr, ADDR_CONFIG)
                                |=> $stable(cfg_q))
    else $error("write outside config changed config");

  a_det_filter: assert property (i_det_done[0] && cfg_q[CFG_DET_CHG_BIT]
                                 && i_det_result[DET_RES_W-1:0] == det_prev_q[0]
                                 |=> !o_det_event[0])
    else $error("unchanged detection reported");

  c_tsd_cycle: cover property (i_tsd_shutdown ##[1:20] alias_rd);
  c_volt_pair: cover property (i_reg_rd && hit(i_reg_addr, ADDR_VSUP_LO)
                               ##[1:10] i_reg_rd && hit(i_reg_addr, ADDR_VSUP_HI));
  c_cfg_write: cover property (i_reg_wr && hit(i_reg_addr, ADDR_CONFIG));
endmodule : pse_gsc_top
`default_nettype wire

/* verif/pse_gsc_host.sv */
// host model driving the register port of the status/config bank
`timescale 1ns/1ps
`default_nettype none
module pse_gsc_host (
  input wire logic i_clk,
  input wire logic [7:0] i_reg_rdata,
  input wire logic i_reg_rvalid,
  output var logic [7:0] o_reg_addr,
  output var logic o_reg_rd,
  output var logic o_reg_wr,
  output var logic [7:0] o_reg_wdata
);
  initial begin
    o_reg_addr = 8'hff;
    o_reg_rd = 1'b0;
    o_reg_wr = 1'b0;
    o_reg_wdata = 8'h00;
  end
  ////////////////////////////////////////////////////////////////////////////
  // one-cycle write; address and data scrambled once released
  task automatic wr8(input logic [7:0] a, input logic [7:0] d);
    @(negedge i_clk);
    o_reg_addr = a;
    o_reg_wdata = d;
    o_reg_wr = 1'b1;
    @(negedge i_clk);
    o_reg_wr = 1'b0;
    o_reg_addr = ~a;
    o_reg_wdata = ~d;
  endtask : wr8
  // one-cycle read; answer stands for one cycle after the taking edge
  task automatic rd8(input logic [7:0] a, output logic [7:0] d, output logic ok);
    @(negedge i_clk);
    o_reg_addr = a;
    o_reg_rd = 1'b1;
    @(negedge i_clk);
    ok = i_reg_rvalid;
    d = i_reg_rdata;
    o_reg_rd = 1'b0;
    o_reg_addr = ~a;
  endtask : rd8
endmodule : pse_gsc_host
`default_nettype wire

/* verif/tb.sv */
// self-checking bench for the global status/config bank
`timescale 1ns/1ps
`default_nettype none
module tb;
  import pse_gsc_pkg::*;
  logic clk = 1'b0;
  logic rst_b = 1'b0;
  logic [7:0] addr, wdata, rdata, cfg;
  logic rd, wr, rvalid, tsd_dis, therm, auto_mode;
  logic [3:0] strap = 4'ha;
  logic auto_pin = 1'b1;
  logic tsd = 1'b0;
  logic [7:0] temp = 8'h00;
  logic [15:0] supply = 16'h0000;
  logic [7:0] det_done = 8'h00;
  logic [23:0] det_res = 24'h000000;
  logic [7:0] det_ev;
  logic [4:0] saddr;
  int fail_count = 0;
  int n_tests = 0;
  ////////////////////////////////////////////////////////////////////////////
  // 40 MHz clock
  initial begin
    forever #12.5 clk = ~clk;
  end
  pse_gsc_host host (.i_clk(clk), .i_reg_rdata(rdata), .i_reg_rvalid(rvalid),
    .o_reg_addr(addr), .o_reg_rd(rd), .o_reg_wr(wr), .o_reg_wdata(wdata));
  pse_gsc_top dut (.i_clk(clk), .i_rst_b(rst_b), .i_reg_addr(addr), .i_reg_rd(rd),
    .i_reg_wr(wr), .i_reg_wdata(wdata), .o_reg_rdata(rdata), .o_reg_rvalid(rvalid),
    .i_addr_strap(strap), .i_auto_pin(auto_pin), .i_tsd_shutdown(tsd),
    .i_die_temp(temp), .i_supply_meas(supply), .i_det_done(det_done),
    .i_det_result(det_res), .o_config(cfg), .o_tsd_disable(tsd_dis),
    .o_thermal_event(therm), .o_slave_addr(saddr), .o_auto_mode(auto_mode),
    .o_det_event(det_ev));
  ////////////////////////////////////////////////////////////////////////////
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    n_tests++;
    if (got !== exp) begin
      fail_count++;
      $display("Error at %0t: saw %h, expected %h", $time, got, exp);
    end
  endtask : chk
  // read and compare, rvalid must stand with the data
  task automatic rchk(input logic [7:0] a, input logic [7:0] exp);
    logic [7:0] d;
    logic ok;
    host.rd8(a, d, ok);
    chk({7'h00, ok}, 8'h01);
    chk(d, exp);
  endtask : rchk
  // one detection pulse on port 0, event checked a cycle later
  task automatic det(input logic [2:0] res, input logic [7:0] exp);
    @(negedge clk);
    det_res = {21'h000000, res};
    det_done = 8'h01;
    @(negedge clk);
    det_done = 8'h00;
    chk(det_ev, exp);
  endtask : det
  task automatic results();
    $display("comparisons %0d, mismatches %0d", n_tests, fail_count);
    if (fail_count == 0 && n_tests > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask : results
  ////////////////////////////////////////////////////////////////////////////
  // watchdog: the sequence needs about 110 cycles
  initial begin
    repeat (3000) @(posedge clk);
    fail_count++;
    results();
  end
  ////////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (10) @(negedge clk);
    rst_b = 1'b1;
    repeat (12) @(negedge clk);
    // reset values and captured pins
    rchk(ADDR_CONFIG, 8'h96);
    chk(cfg, 8'h96);
    rchk(ADDR_STATUS, 8'h29);
    chk({3'h0, saddr}, 8'h0a);
    // pins move after capture: status must not follow
    strap = 4'h5;
    auto_pin = 1'b0;
    repeat (10) @(negedge clk);
    rchk(ADDR_STATUS, 8'h29);
    chk({7'h00, auto_mode}, 8'h01);
    // read-only places ignore writes, reserved bits stay zero
    host.wr8(ADDR_STATUS, 8'hff);
    rchk(ADDR_STATUS, 8'h29);
    rchk(8'h01, 8'h00);
    // temperature code passes through at both ends of its range
    temp = 8'hff;
    rchk(ADDR_TEMP, 8'hff);
    temp = 8'h00;
    host.wr8(ADDR_TEMP, 8'h55);
    rchk(ADDR_TEMP, 8'h00);
    // low byte first; high byte frozen to the same sample
    supply = 16'h1234;
    rchk(ADDR_VSUP_LO, 8'h34);
    supply = 16'hab56;
    rchk(ADDR_VSUP_HI, 8'h12);
    rchk(ADDR_VSUP_HI, 8'hab);
    // config layout and shutdown-disable output
    host.wr8(ADDR_CONFIG, 8'h20);
    rchk(ADDR_CONFIG, 8'h20);
    chk({7'h00, tsd_dis}, 8'h01);
    host.wr8(ADDR_CONFIG, 8'h5a);
    chk(cfg, 8'h5a);
    chk({7'h00, tsd_dis}, 8'h00);
    // thermal flag: set, latched, cleared by the alias read only
    @(negedge clk);
    tsd = 1'b1;
    @(negedge clk);
    tsd = 1'b0;
    repeat (3) @(negedge clk);
    chk({7'h00, therm}, 8'h01);
    rchk(ADDR_STATUS, 8'h29);
    chk({7'h00, therm}, 8'h01);
    rchk(ADDR_EVT_ALIAS, 8'h08);
    chk({7'h00, therm}, 8'h00);
    rchk(ADDR_EVT_ALIAS, 8'h00);
    // detection events with change-only off, then on
    host.wr8(ADDR_CONFIG, 8'h00);
    det(3'h0, 8'h01);
    det(3'h0, 8'h01);
    host.wr8(ADDR_CONFIG, 8'h40);
    det(3'h0, 8'h00);
    det(3'h5, 8'h01);
    det(3'h5, 8'h00);
    // mid-run reset: config back to default, straps taken afresh from the new levels
    @(negedge clk);
    rst_b = 1'b0;
    repeat (10) @(negedge clk);
    chk(cfg, 8'h96);
    chk({3'h0, saddr}, 8'h00);
    rst_b = 1'b1;
    repeat (12) @(negedge clk);
    rchk(ADDR_STATUS, 8'h14);
    chk({7'h00, auto_mode}, 8'h00);
    results();
  end
endmodule : tb
`default_nettype wire
